// ### hw/epc_defs.vh
// constants for the eprom programming control block
`ifndef EPC_DEFS_VH
`define EPC_DEFS_VH

`define EPC_BUS_AW 8
`define EPC_OFF_EPROM_PROGRAM_CTRL 8'h00
`define EPC_OFF_STATUS 8'h04
`define EPC_OFF_LED 8'h08
`define EPC_OFF_EADDR 8'h0C
`define EPC_OFF_EDATA 8'h10

`define EPC_EPROM_PROGRAM_CTRL_LATCH_BIT 2
`define EPC_EPROM_PROGRAM_CTRL_VOLT_BIT 0
`define EPC_EPROM_PROGRAM_CTRL_RESET 8'h00

`define EPC_ST_BOOT_BIT 0
`define EPC_ST_VOLT_BIT 1
`define EPC_ST_CAPT_BIT 2
`define EPC_ST_DONE_BIT 3
`define EPC_ST_FUNC_LO 4
`define EPC_ST_FUNC_HI 5

`define EPC_LED_EPROM_PROGRAM_CTRL_BIT 0
`define EPC_LED_VERIFY_BIT 1
`define EPC_LED_RESET 8'h00

`define EPC_EPROM_AW 14
`define EPC_ARRAY_AW 8
`define EPC_ARRAY_DEPTH 256
`define EPC_BOOT_ROM_START 14'h3F00
`define EPC_BOOT_ROM_END 14'h3FEF
`define EPC_BOOT_ROM_FILL 8'h9D
`define EPC_BLOCKED_READ 8'hFF
`define EPC_ERASED 8'hFF

`define EPC_FUNC_EPROM_PROGRAM_CTRL_VERIFY 2'h0
`define EPC_FUNC_VERIFY 2'h1
`define EPC_FUNC_LOAD_RAM 2'h2
`define EPC_FUNC_SECURE 2'h3

`define EPC_CLK_MHZ 250
`define EPC_PGM_TIME_US 4000
`define EPC_PGM_CYCLES (`EPC_PGM_TIME_US * `EPC_CLK_MHZ)

`endif

// ### hw/epc_array.v
// byte-wide eprom array with registered read data
`timescale 1ns/1ps
`include "epc_defs.vh"
module epc_array (
    input wire core_clk,
    input wire wr_en,
    input wire [`EPC_ARRAY_AW-1:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [`EPC_ARRAY_AW-1:0] rd_addr,
    output reg [7:0] rd_data
);
    reg [7:0] mem [0:`EPC_ARRAY_DEPTH-1];
    integer i;

    // erased state at start of simulation; real cells come up erased too
    initial begin
        for (i = 0; i < `EPC_ARRAY_DEPTH; i = i + 1) begin
            mem[i] = `EPC_ERASED;
        end
    end

    always @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ### hw/epc_mode_strap.v
// catches the operating mode at reset release and decodes the function pins
`timescale 1ns/1ps
`include "epc_defs.vh"
module epc_mode_strap (
    input wire core_clk,
    input wire reset,
    input wire test_entry_voltage,
    input wire timer_capture_pin,
    input wire func_sel_2,
    input wire func_sel_1,
    input wire func_sel_0,
    output reg boot_mode_reg,
    output reg [1:0] func_code_reg
);
    reg captured_reg;

    function [1:0] decode_func;
        input [2:0] sel;
        begin
            if (sel[2]) begin
                decode_func = `EPC_FUNC_SECURE;
            end else if (sel[1:0] == 2'h0) begin
                decode_func = `EPC_FUNC_EPROM_PROGRAM_CTRL_VERIFY;
            end else if (sel[1:0] == 2'h1) begin
                decode_func = `EPC_FUNC_VERIFY;
            end else if (sel[1:0] == 2'h2) begin
                decode_func = `EPC_FUNC_LOAD_RAM;
            end else begin
                // pattern 011 is undefined; treat as verify only, the harmless choice
                decode_func = `EPC_FUNC_VERIFY;
            end
        end
    endfunction

    always @(posedge core_clk) begin
        if (reset) begin
            captured_reg <= 1'b0;
            boot_mode_reg <= 1'b0;
        end else if (!captured_reg) begin
            // first edge after release stands for the reset rising edge
            boot_mode_reg <= test_entry_voltage & timer_capture_pin; // [R1]
            captured_reg <= 1'b1;
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            func_code_reg <= `EPC_FUNC_EPROM_PROGRAM_CTRL_VERIFY;
        end else begin
            func_code_reg <= decode_func({func_sel_2, func_sel_1, func_sel_0}); // [R4]
        end
    end
endmodule

// ### hw/epc_top.v
// eprom programming control: mode strap, programming register, latches, leds
// Notes on behaviour
// (R1) At reset release the block enters bootloader mode only if the test voltage and capture pin are both high.
// (R2) Eprom addresses 3F00 to 3FEF read the fixed bootloader rom and are never programmed.
// (R3) The source of user code must use addresses that map one to one onto the eprom array.
// (R4) The three select pins pick program/verify, verify, load ram, or secure when the top pin is high.
// (R5) In bootloader mode two outputs drive the programming and verification leds.
// (R6) Software sets the latch bit, writes the byte to its address, then holds the program bit for the programming time.
// (R7) While the latch bit is set the first write to an eprom location captures its address and data.
// (R8) Eprom reads are blocked while the latch bit is set.
// (R9) With the latch bit clear the eprom path is in normal read configuration.
// (R10) Latch and program bits read back and are written by software.
// (R11) The program bit turns the programming voltage on and clearing it turns it off.
// (R12) The program bit can be set only when the latch bit was already set by an earlier write.
// (R13) One write that sets both bits from a clear latch sets only the latch bit.
// (R14) Software writes zero to bits 7 to 3 and bit 1 of the programming register.
// (R15) Clearing the program bit ends the pulse and clearing the latch then releases the latches.
`timescale 1ns/1ps
`include "epc_defs.vh"
module epc_top #(
    parameter [31:0] PGM_CYCLES = `EPC_PGM_CYCLES
) (
    input wire core_clk,
    input wire reset,
    input wire [`EPC_BUS_AW-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire test_entry_voltage,
    input wire timer_capture_pin,
    input wire func_sel_2,
    input wire func_sel_1,
    input wire func_sel_0,
    output reg eprom_program_ctrl_led_out,
    output reg verify_led_out,
    output reg program_voltage_on
);
    localparam [1:0] BUS_IDLE = 2'h0;
    localparam [1:0] BUS_PREP = 2'h1;
    localparam [1:0] BUS_DONE = 2'h2;
    // reset image of the programming register; bits are picked out below
    localparam [7:0] EPROM_PROGRAM_CTRL_RESET_VAL = `EPC_EPROM_PROGRAM_CTRL_RESET;

    reg [1:0] bus_state_reg;
    reg [1:0] bus_state_next;
    reg latch_reg;
    reg volt_reg;
    reg captured_reg;
    reg done_reg;
    reg [`EPC_EPROM_AW-1:0] eaddr_reg;
    reg [`EPC_EPROM_AW-1:0] lat_addr_reg;
    reg [7:0] lat_data_reg;
    reg [7:0] led_reg;
    reg [31:0] pgm_cnt_reg;
    reg arr_wr_reg;
    reg [31:0] rdata_next;
    reg latch_next;
    reg volt_next;
    reg [31:0] pgm_cnt_next;
    reg eprom_program_ctrl_led_next;
    reg verify_led_next;

    wire boot_mode;
    wire [1:0] func_code;
    wire [7:0] arr_rd_data;
    wire accept;
    wire wr_acc;
    wire [7:0] wbyte;
    wire wr_eprom_program_ctrl;
    wire wr_eaddr;
    wire wr_edata;
    wire wr_led;
    wire pgm_run;
    wire pgm_last;

    function in_boot_rom;
        input [`EPC_EPROM_AW-1:0] a;
        begin
            in_boot_rom = (a >= `EPC_BOOT_ROM_START) && (a <= `EPC_BOOT_ROM_END);
        end
    endfunction

    // write accepted at the given offset this cycle
    function reg_write;
        input acc;
        input [`EPC_BUS_AW-1:0] addr;
        input [`EPC_BUS_AW-1:0] off;
        begin
            reg_write = acc && (addr == off);
        end
    endfunction

    epc_mode_strap u_strap (
        .core_clk(core_clk),
        .reset(reset),
        .test_entry_voltage(test_entry_voltage),
        .timer_capture_pin(timer_capture_pin),
        .func_sel_2(func_sel_2),
        .func_sel_1(func_sel_1),
        .func_sel_0(func_sel_0),
        .boot_mode_reg(boot_mode),
        .func_code_reg(func_code)
    );

    epc_array u_array (
        .core_clk(core_clk),
        .wr_en(arr_wr_reg),
        .wr_addr(lat_addr_reg[`EPC_ARRAY_AW-1:0]),
        .wr_data(lat_data_reg),
        .rd_addr(eaddr_reg[`EPC_ARRAY_AW-1:0]),
        .rd_data(arr_rd_data)
    );

    // two wait cycles give the array's registered read time to settle
    always @* begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_state_next = BUS_PREP;
                end
            end
            BUS_PREP: begin
                bus_state_next = BUS_DONE;
            end
            BUS_DONE: begin
                bus_state_next = BUS_IDLE;
            end
            default: begin
                bus_state_next = BUS_IDLE;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (reset) begin
            bus_state_reg <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            bus_state_reg <= bus_state_next;
            avs_waitrequest <= (bus_state_next != BUS_DONE);
        end
    end

    assign accept = (bus_state_reg == BUS_DONE);
    assign wr_acc = accept && avs_write;
    assign wbyte = avs_writedata[7:0];
    assign wr_eprom_program_ctrl = reg_write(wr_acc, avs_address, `EPC_OFF_EPROM_PROGRAM_CTRL);
    assign wr_eaddr = reg_write(wr_acc, avs_address, `EPC_OFF_EADDR);
    assign wr_edata = reg_write(wr_acc, avs_address, `EPC_OFF_EDATA);
    assign wr_led = reg_write(wr_acc, avs_address, `EPC_OFF_LED);
    assign pgm_run = volt_reg && captured_reg;
    assign pgm_last = pgm_run && (pgm_cnt_reg == PGM_CYCLES - 32'h0000_0001);

    // read mux, loaded one edge before the accepting edge
    always @* begin
        rdata_next = 32'h0000_0000;
        case (avs_address)
            `EPC_OFF_EPROM_PROGRAM_CTRL: begin
                rdata_next[`EPC_EPROM_PROGRAM_CTRL_LATCH_BIT] = latch_reg; // [R10]
                rdata_next[`EPC_EPROM_PROGRAM_CTRL_VOLT_BIT] = volt_reg; // [R10]
            end
            `EPC_OFF_STATUS: begin
                rdata_next[`EPC_ST_BOOT_BIT] = boot_mode;
                rdata_next[`EPC_ST_VOLT_BIT] = volt_reg;
                rdata_next[`EPC_ST_CAPT_BIT] = captured_reg;
                rdata_next[`EPC_ST_DONE_BIT] = done_reg;
                rdata_next[`EPC_ST_FUNC_HI:`EPC_ST_FUNC_LO] = func_code;
            end
            `EPC_OFF_LED: begin
                rdata_next[7:0] = led_reg;
            end
            `EPC_OFF_EADDR: begin
                rdata_next[`EPC_EPROM_AW-1:0] = eaddr_reg;
            end
            `EPC_OFF_EDATA: begin
                if (latch_reg) begin
                    rdata_next[7:0] = `EPC_BLOCKED_READ; // [R8]
                end else if (in_boot_rom(eaddr_reg)) begin
                    rdata_next[7:0] = `EPC_BOOT_ROM_FILL; // [R2]
                end else begin
                    rdata_next[7:0] = arr_rd_data; // [R9]
                end
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
        end else if (bus_state_reg == BUS_PREP) begin
            avs_readdata <= avs_read ? rdata_next : 32'h0000_0000;
        end
    end

    // programming register; reserved bits are simply not stored
    always @* begin
        latch_next = latch_reg;
        volt_next = volt_reg;
        if (wr_eprom_program_ctrl) begin
            latch_next = wbyte[`EPC_EPROM_PROGRAM_CTRL_LATCH_BIT]; // [R10] [R15]
            // the voltage bit only sets if latch was already 1 before this write
            volt_next = wbyte[`EPC_EPROM_PROGRAM_CTRL_VOLT_BIT] & latch_reg; // [R11] [R12] [R13]
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            latch_reg <= EPROM_PROGRAM_CTRL_RESET_VAL[`EPC_EPROM_PROGRAM_CTRL_LATCH_BIT];
            volt_reg <= EPROM_PROGRAM_CTRL_RESET_VAL[`EPC_EPROM_PROGRAM_CTRL_VOLT_BIT];
        end else begin
            latch_reg <= latch_next;
            volt_reg <= volt_next;
        end
    end

    // captures the first eprom write after latch is set; held until latch clears
    always @(posedge core_clk) begin
        if (reset) begin
            captured_reg <= 1'b0;
            lat_addr_reg <= {`EPC_EPROM_AW{1'b0}};
            lat_data_reg <= 8'h00;
        end else if (!latch_reg) begin
            captured_reg <= 1'b0; // [R15]
        end else if (wr_edata && !captured_reg) begin
            captured_reg <= 1'b1; // [R7]
            lat_addr_reg <= eaddr_reg; // [R7]
            lat_data_reg <= wbyte; // [R7]
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            eaddr_reg <= {`EPC_EPROM_AW{1'b0}};
        end else if (wr_eaddr) begin
            eaddr_reg <= avs_writedata[`EPC_EPROM_AW-1:0];
        end
    end

    // pulse timer: the byte is committed once the voltage has stood the full time
    always @* begin
        pgm_cnt_next = pgm_cnt_reg;
        if (!pgm_run) begin
            pgm_cnt_next = 32'h0000_0000; // [R15]
        end else if (pgm_cnt_reg < PGM_CYCLES) begin
            pgm_cnt_next = pgm_cnt_reg + 32'h0000_0001;
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            pgm_cnt_reg <= 32'h0000_0000;
            arr_wr_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            pgm_cnt_reg <= pgm_cnt_next;
            // rom range cannot be programmed; address wraps onto the array
            arr_wr_reg <= pgm_last && !in_boot_rom(lat_addr_reg); // [R2] [R11]
            if (pgm_last) begin
                done_reg <= 1'b1;
            end else if (!pgm_run && !latch_reg) begin
                done_reg <= 1'b0;
            end
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            led_reg <= `EPC_LED_RESET;
        end else if (wr_led) begin
            led_reg <= {6'h00, wbyte[1:0]};
        end
    end

    // leds only light in bootloader mode, whatever software wrote
    always @* begin
        eprom_program_ctrl_led_next = 1'b0;
        verify_led_next = 1'b0;
        if (boot_mode) begin
            eprom_program_ctrl_led_next = led_reg[`EPC_LED_EPROM_PROGRAM_CTRL_BIT]; // [R5]
            verify_led_next = led_reg[`EPC_LED_VERIFY_BIT]; // [R5]
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            eprom_program_ctrl_led_out <= 1'b0;
            verify_led_out <= 1'b0;
            program_voltage_on <= 1'b0;
        end else begin
            eprom_program_ctrl_led_out <= eprom_program_ctrl_led_next;
            verify_led_out <= verify_led_next;
            program_voltage_on <= volt_reg; // [R11]
        end
    end
endmodule

// ### testbench/epc_code_src.sv
// host model that presents user code bytes for the bootloader
`timescale 1ns/1ps
module epc_code_src (
    input wire [1:0] idx,
    output wire [13:0] addr,
    output wire [7:0] data
);
    // each byte owns its own array cell, so no two share an address
    assign addr = {12'h012, idx};
    assign data = 8'h5A ^ {idx, idx, idx, idx};
endmodule

// ### testbench/epc_checker.sv
// port assertions for the eprom programming control block
`timescale 1ns/1ps
`include "epc_defs.vh"
module epc_checker (
    input wire core_clk,
    input wire reset,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire test_entry_voltage,
    input wire timer_capture_pin,
    input wire eprom_program_ctrl_led_out,
    input wire verify_led_out,
    input wire program_voltage_on
);
    reg latch_reg;
    reg boot_reg;
    reg rst_d_reg;
    reg [13:0] eaddr_reg;
    wire wr = !avs_waitrequest && avs_write;
    wire rd_e = !avs_waitrequest && avs_read && avs_address == `EPC_OFF_EDATA;
    wire rom = eaddr_reg >= `EPC_BOOT_ROM_START && eaddr_reg <= `EPC_BOOT_ROM_END;
    always @(posedge core_clk) begin
        rst_d_reg <= reset;
        if (reset) begin
            latch_reg <= 1'b0;
            eaddr_reg <= 14'h0000;
        end else begin
            // strap is taken at the first edge that sees reset low
            if (rst_d_reg) begin
                boot_reg <= test_entry_voltage && timer_capture_pin;
            end
            if (wr && avs_address == `EPC_OFF_EPROM_PROGRAM_CTRL) begin
                latch_reg <= avs_writedata[2];
            end
            if (wr && avs_address == `EPC_OFF_EADDR) begin
                eaddr_reg <= avs_writedata[13:0];
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_eprom_program_ctrl_wr;
        wr && avs_address == `EPC_OFF_EPROM_PROGRAM_CTRL;
    endsequence
    sequence s_volt_req;
        s_eprom_program_ctrl_wr ##0 avs_writedata[0] && latch_reg;
    endsequence
    a_answer_time: assert property ((avs_read || avs_write) && avs_waitrequest
        |-> ##[1:2] !avs_waitrequest) else $error("bus answer late");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_volt_blocked: assert property (s_eprom_program_ctrl_wr ##0 avs_writedata[0] && !latch_reg
        |=> !program_voltage_on [*2]) else $error("voltage without latch");
    a_volt_apply: assert property (s_volt_req ##0 avs_writedata[2]
        |=> ##1 program_voltage_on) else $error("voltage not applied");
    a_volt_remove: assert property (s_eprom_program_ctrl_wr ##0 !avs_writedata[0]
        |=> ##1 !program_voltage_on) else $error("voltage not removed");
    a_volt_cause: assert property ($changed(program_voltage_on)
        |-> $past(wr && avs_address == `EPC_OFF_EPROM_PROGRAM_CTRL, 2)) else $error("voltage moved alone");
    a_led_gate: assert property (eprom_program_ctrl_led_out || verify_led_out |-> boot_reg)
        else $error("led lit outside boot mode");
    a_led_follow: assert property (wr && avs_address == `EPC_OFF_LED && boot_reg
        && avs_writedata[1:0] == 2'h3 |=> ##[0:1] eprom_program_ctrl_led_out && verify_led_out)
        else $error("leds not lit");
    a_read_blocked: assert property (rd_e && latch_reg
        |-> avs_readdata[7:0] == `EPC_BLOCKED_READ) else $error("read not blocked");
    a_rom_read: assert property (rd_e && !latch_reg && rom
        |-> avs_readdata[7:0] == `EPC_BOOT_ROM_FILL) else $error("boot rom read wrong");
endmodule
bind epc_top epc_checker chk (.core_clk(core_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .test_entry_voltage(test_entry_voltage),
    .timer_capture_pin(timer_capture_pin), .eprom_program_ctrl_led_out(eprom_program_ctrl_led_out),
    .verify_led_out(verify_led_out), .program_voltage_on(program_voltage_on));

// ### testbench/test_eprom_program_control.sv
// self-checking bench for the eprom programming control block
`timescale 1ns/1ps
`include "epc_defs.vh"
module test_eprom_program_control;
    localparam PGM = 16;
    reg core_clk = 1'b0;
    reg reset = 1'b1;
    reg [7:0] avs_address = 8'h00;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0;
    reg test_entry_voltage = 1'b1;
    reg timer_capture_pin = 1'b1;
    reg [2:0] sel = 3'h0;
    reg [1:0] idx = 2'h0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire [13:0] src_addr;
    wire [7:0] src_data;
    wire led_p;
    wire led_v;
    wire volt;
    reg [31:0] rd;
    integer errors = 0;
    integer n_checks = 0;
    integer i;
    always #2 core_clk = ~core_clk;
    epc_top #(.PGM_CYCLES(PGM)) dut (.core_clk(core_clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .test_entry_voltage(test_entry_voltage),
        .timer_capture_pin(timer_capture_pin), .func_sel_2(sel[2]), .func_sel_1(sel[1]),
        .func_sel_0(sel[0]), .eprom_program_ctrl_led_out(led_p), .verify_led_out(led_v),
        .program_voltage_on(volt));
    epc_code_src src (.idx(idx), .addr(src_addr), .data(src_data));
    task test_done;
        begin
            if (errors == 0 && n_checks > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask
    task check(input [63:0] what, input [31:0] exp, input [31:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("Error %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // request held until waitrequest is sampled low, released only after
    task bus(input wr, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge core_clk);
            avs_address <= a;
            avs_writedata <= d;
            avs_read <= !wr;
            avs_write <= wr;
            n = 0;
            @(posedge core_clk);
            while (avs_waitrequest !== 1'b0 && n < 20) begin
                n = n + 1;
                @(posedge core_clk);
            end
            if (n == 20) begin
                check("timeout", 32'h0, 32'h1);
                test_done;
            end else begin
                rd = avs_readdata;
                avs_read <= 1'b0;
                avs_write <= 1'b0;
            end
        end
    endtask
    task w(input [7:0] a, input [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rchk(input [63:0] what, input [7:0] a, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0);
            check(what, e, rd);
        end
    endtask
    task do_reset(input v, input c);
        begin
            reset <= 1'b1;
            test_entry_voltage <= v;
            timer_capture_pin <= c;
            repeat (20) @(posedge core_clk);
            reset <= 1'b0;
        end
    endtask
    task t_start;
        begin
            rchk("eprom_program_ctrl", `EPC_OFF_EPROM_PROGRAM_CTRL, 32'h0);
            check("volt", 32'h0, volt);
            rchk("led", `EPC_OFF_LED, 32'h0);
            bus(1'b0, `EPC_OFF_STATUS, 32'h0);
            check("boot", 32'h1, rd[0]);
        end
    endtask
    task t_func;
        for (i = 0; i < 8; i = i + 1) begin
            sel <= i[2:0];
            bus(1'b0, `EPC_OFF_STATUS, 32'h0);
            check("func", i[2] ? 3 : i[0] ? 1 : i[1] ? 2 : 0, rd[5:4]);
        end
    endtask
    task t_led(input boot);
        begin
            w(`EPC_OFF_LED, 32'h3);
            @(posedge core_clk);
            #1;
            check("leds", {boot, boot}, {led_v, led_p});
            w(`EPC_OFF_LED, 32'h0);
        end
    endtask
    task t_both;
        begin
            w(`EPC_OFF_EPROM_PROGRAM_CTRL, 32'h5);
            rchk("latch", `EPC_OFF_EPROM_PROGRAM_CTRL, 32'h4);
            check("volt", 32'h0, volt);
            w(`EPC_OFF_EPROM_PROGRAM_CTRL, 32'h0);
        end
    endtask
    task t_eprom_program_ctrl;
        for (i = 0; i < 2; i = i + 1) begin
            idx <= i[1:0];
            w(`EPC_OFF_EPROM_PROGRAM_CTRL, 32'h4);
            rchk("blocked", `EPC_OFF_EDATA, 32'hFF);
            w(`EPC_OFF_EADDR, {18'h0, src_addr});
            w(`EPC_OFF_EDATA, {24'h0, src_data});
            w(`EPC_OFF_EDATA, {24'h0, ~src_data});
            bus(1'b0, `EPC_OFF_STATUS, 32'h0);
            check("capt", 32'h1, rd[2]);
            w(`EPC_OFF_EPROM_PROGRAM_CTRL, 32'h5);
            rchk("eprom_program_ctrl", `EPC_OFF_EPROM_PROGRAM_CTRL, 32'h5);
            check("volt", 32'h1, volt);
            repeat (PGM + 4) @(posedge core_clk);
            bus(1'b0, `EPC_OFF_STATUS, 32'h0);
            check("done", 32'h1, rd[3]);
            w(`EPC_OFF_EPROM_PROGRAM_CTRL, 32'h4);
            w(`EPC_OFF_EPROM_PROGRAM_CTRL, 32'h0);
            check("volt", 32'h0, volt);
            rchk("byte", `EPC_OFF_EDATA, {24'h0, src_data});
        end
    endtask
    task t_rom;
        begin
            w(`EPC_OFF_EADDR, 32'h3F00);
            rchk("rom", `EPC_OFF_EDATA, `EPC_BOOT_ROM_FILL);
            w(`EPC_OFF_EADDR, 32'h3FEF);
            rchk("rom", `EPC_OFF_EDATA, `EPC_BOOT_ROM_FILL);
            w(`EPC_OFF_EADDR, 32'h3FF0);
            rchk("erased", `EPC_OFF_EDATA, `EPC_ERASED);
            w(8'h14, 32'hFF);
            rchk("unmap", 8'h14, 32'h0);
        end
    endtask
    task t_user;
        for (i = 1; i < 3; i = i + 1) begin
            do_reset(i[0], i[1]);
            bus(1'b0, `EPC_OFF_STATUS, 32'h0);
            check("boot", 32'h0, rd[0]);
            t_led(1'b0);
        end
    endtask
    initial begin
        do_reset(1'b1, 1'b1);
        t_start;
        t_func;
        t_led(1'b1);
        t_both;
        t_eprom_program_ctrl;
        t_rom;
        t_user;
        test_done;
    end
endmodule
